// *** rtl/esr_ramp.sv ***
// Engine speed reference ramp with Wishbone register access
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "esr_defs.svh"

module esr_ramp
	import esr_pkg::*;
#(
	parameter int TICK_CYCLES = `ESR_TICK_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic [31:0]      wb_dat_o,
	input  wire logic        raise_cmd,
	input  wire logic        lower_cmd,
	input  wire logic        rated_sel,
	input  wire logic [15:0] remote_ua,
	output logic [15:0]      speed_setpoint,
	output logic             ramp_active,
	output logic             remote_fail
);

	esr_state_t    s_reg;
	esr_state_t    s_next;
	esr_wb_req_t   req;
	esr_contacts_t con;

	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
		sel: wb_sel_i, dat: wb_dat_i};
	assign con = '{raise: raise_cmd, lower: lower_cmd, rated_sel: rated_sel,
		remote_ua: remote_ua};

	function automatic logic [31:0] cfg_reset(input int idx);
		case (idx)
			0:       cfg_reset = `ESR_RST_CTRL;
			1:       cfg_reset = `ESR_RST_IDLE;
			2:       cfg_reset = `ESR_RST_RATED;
			3:       cfg_reset = `ESR_RST_LOW_LIM;
			4:       cfg_reset = `ESR_RST_UP_LIM;
			5:       cfg_reset = `ESR_RST_ACCEL;
			6:       cfg_reset = `ESR_RST_DECEL;
			7:       cfg_reset = `ESR_RST_RAISE_RT;
			8:       cfg_reset = `ESR_RST_LOWER_RT;
			9:       cfg_reset = `ESR_RST_REM_LOW;
			default: cfg_reset = `ESR_RST_REM_HIGH;
		endcase
	endfunction

	function automatic logic [31:0] cfg_mask(input logic [3:0] idx);
		if (idx == `ESR_IDX_CTRL) begin
			cfg_mask = `ESR_MASK_CTRL;
		end else if (idx == `ESR_IDX_RAISE_RT || idx == `ESR_IDX_LOWER_RT) begin
			cfg_mask = `ESR_MASK_RATE;
		end else begin
			cfg_mask = `ESR_MASK_SPD;
		end
	endfunction

	// Move cur toward tgt by at most step; a jump that would pass tgt lands on it
	function automatic logic [31:0] step_to(input logic [31:0] cur,
		input logic [31:0] tgt, input logic [31:0] step);
		logic [32:0] up;
		logic [32:0] dn;
		up = {1'b0, cur} + {1'b0, step};
		dn = {1'b0, cur} - {1'b0, step};
		if (cur < tgt) begin
			step_to = (up >= {1'b0, tgt}) ? tgt : up[31:0];
		end else if (cur > tgt) begin
			step_to = (dn[32] || dn[31:0] <= tgt) ? tgt : dn[31:0];
		end else begin
			step_to = cur;
		end
	endfunction

	function automatic logic [31:0] to_fx(input logic [31:0] rpm);
		to_fx = {rpm[15:0], 16'h0000};
	endfunction

	logic [3:0]  widx;
	logic [31:0] idle_fx;
	logic [31:0] rated_fx;
	logic [31:0] low_fx;
	logic [31:0] up_fx;
	logic [31:0] rem_fx;
	logic [15:0] cal_low;
	logic [15:0] cal_high;
	logic [15:0] cal_diff;
	logic [15:0] span_in;
	logic        remote_sel;
	logic        remote_ok;
	logic        tick;
	logic        hold_on_loss;

	assign widx         = req.adr[5:2];
	assign cal_low      = s_reg.cfg[`ESR_IDX_REM_LOW][15:0];
	assign cal_high     = s_reg.cfg[`ESR_IDX_REM_HIGH][15:0];
	assign idle_fx      = to_fx(s_reg.cfg[`ESR_IDX_IDLE]);
	assign rated_fx     = to_fx(s_reg.cfg[`ESR_IDX_RATED]);
	assign low_fx       = to_fx(s_reg.cfg[`ESR_IDX_LOW_LIM]);
	assign up_fx        = to_fx(s_reg.cfg[`ESR_IDX_UP_LIM]);
	assign hold_on_loss = s_reg.cfg[`ESR_IDX_CTRL][`ESR_CTRL_HOLD_BIT];
	assign remote_sel   = con.raise & con.lower;
	assign remote_ok    = remote_sel & ~s_reg.in_failed;
	assign tick         = (s_reg.tick_cnt == 16'(TICK_CYCLES - 1));
	assign cal_diff     = (cal_high >= cal_low) ? cal_high - cal_low : cal_low - cal_high;
	// Readings outside the span sit at the nearer calibration end
	assign span_in      = (con.remote_ua < `ESR_SPAN_LO_UA) ? 16'h0000 :
		(con.remote_ua > `ESR_SPAN_HI_UA) ? `ESR_SPAN_UA : con.remote_ua - `ESR_SPAN_LO_UA;

	always_comb begin
		rem_fx = to_fx({16'h0000, s_reg.remote_ref});
		if (rem_fx > up_fx) begin
			rem_fx = up_fx;
		end
		if (rem_fx < low_fx) begin
			rem_fx = low_fx;
		end
	end

	always_comb begin
		logic [31:0] wval;
		logic [31:0] delta;
		logic [16:0] r;
		s_next = s_reg;
		wval   = 32'h0000_0000;
		delta  = 32'h0000_0000;
		r      = 17'h0_0000;

		// Wishbone slave: one wait state, ack held for one cycle only
		s_next.ack = req.cyc & req.stb & ~s_reg.ack;
		if (req.cyc && req.stb && !s_reg.ack) begin
			if (req.we && widx < 4'(`ESR_NUM_CFG)) begin
				wval = s_reg.cfg[widx];
				for (int b = 0; b < 4; b++) begin
					if (req.sel[b]) begin
						wval[b*8 +: 8] = req.dat[b*8 +: 8];
					end
				end
				s_next.cfg[widx] = wval & cfg_mask(widx);
			end
			unique case (widx)
				`ESR_IDX_STATUS: begin
					s_next.rdata = {26'h0, s_reg.rem_alarm, s_reg.in_failed, remote_sel,
						(s_reg.mode != ESR_ST_IDLE && s_reg.mode != ESR_ST_RATED),
						s_reg.mode};
				end
				`ESR_IDX_SETPOINT: begin
					s_next.rdata = s_reg.sp;
				end
				default: begin
					s_next.rdata = (widx < 4'(`ESR_NUM_CFG)) ? s_reg.cfg[widx] : 32'h0000_0000;
				end
			endcase
		end

		s_next.tick_cnt = tick ? 16'h0000 : s_reg.tick_cnt + 16'h0001;
		s_next.in_failed = (con.remote_ua < `ESR_FAIL_UA);
		// alarm when remote lost and not held
		s_next.rem_alarm = remote_sel & s_reg.in_failed & ~hold_on_loss;

		// Shared serial divider cycles through ramp steps and remote scaling,
		// trading a few microseconds of latency for a single divider
		// Limitation: a calibration or input change reaches the remote
		// reference up to a round and a third later, so hosts let that much pass
		if (s_reg.div_cnt == 6'd0) begin
			unique case (s_reg.job)
				ESR_JOB_ACCEL:  s_next.accel_step = s_reg.div_quo;
				ESR_JOB_DECEL:  s_next.decel_step = s_reg.div_quo;
				ESR_JOB_REMOTE: begin
					s_next.remote_ref = s_reg.rem_neg ? cal_low - s_reg.div_quo[15:0]
						: cal_low + s_reg.div_quo[15:0];
				end
				default: s_next.remote_ref = s_reg.remote_ref;
			endcase
			delta = s_reg.cfg[`ESR_IDX_RATED] - s_reg.cfg[`ESR_IDX_IDLE];
			s_next.div_rem = 17'h0_0000;
			s_next.div_quo = 32'h0000_0000;
			s_next.div_cnt = 6'd32;
			unique case (s_reg.job)
				ESR_JOB_ACCEL: begin
					// decel step from span and time
					s_next.job     = ESR_JOB_DECEL;
					s_next.div_dvd = {delta[15:0], 16'h0000};
					s_next.div_dsr = s_reg.cfg[`ESR_IDX_DECEL][15:0];
				end
				ESR_JOB_DECEL: begin
					s_next.job     = ESR_JOB_REMOTE;
					s_next.div_dvd = {16'h0000, cal_diff} * {16'h0000, span_in};
					s_next.div_dsr = `ESR_SPAN_UA;
					s_next.rem_neg = (cal_high < cal_low);
				end
				default: begin
					// accel step from span and time
					s_next.job     = ESR_JOB_ACCEL;
					s_next.div_dvd = {delta[15:0], 16'h0000};
					s_next.div_dsr = s_reg.cfg[`ESR_IDX_ACCEL][15:0];
				end
			endcase
		end else begin
			r = {s_reg.div_rem[15:0], s_reg.div_dvd[31]};
			s_next.div_dvd = {s_reg.div_dvd[30:0], 1'b0};
			s_next.div_cnt = s_reg.div_cnt - 6'd1;
			if (r >= {1'b0, s_reg.div_dsr}) begin
				s_next.div_rem = r - {1'b0, s_reg.div_dsr};
				s_next.div_quo = {s_reg.div_quo[30:0], 1'b1};
			end else begin
				s_next.div_rem = r;
				s_next.div_quo = {s_reg.div_quo[30:0], 1'b0};
			end
		end

		if (tick) begin
			unique case (s_reg.mode)
				ESR_ST_IDLE: begin
					s_next.sp = idle_fx;
					if (con.rated_sel) begin
						// remote already valid: track at raise or lower rate
						s_next.mode = remote_ok ? ESR_ST_RATED : ESR_ST_ACCEL;
					end
				end
				ESR_ST_ACCEL: begin
					if (!con.rated_sel) begin
						s_next.mode = ESR_ST_DECEL;
					end else if (remote_ok) begin
						s_next.mode = ESR_ST_RATED;
					end else if (con.raise ^ con.lower) begin
						s_next.mode = ESR_ST_RATED;
					end else begin
						s_next.sp = step_to(s_reg.sp, rated_fx, s_reg.accel_step);
						if (s_next.sp == rated_fx) begin
							s_next.mode = ESR_ST_RATED;
						end
					end
				end
				ESR_ST_RATED: begin
					if (!con.rated_sel) begin
						s_next.mode = ESR_ST_DECEL;
					end else if (remote_sel) begin
						if (remote_ok) begin
							// slew at raise or lower rate
							s_next.sp = step_to(s_reg.sp, rem_fx, (s_reg.sp < rem_fx) ?
								s_reg.cfg[`ESR_IDX_RAISE_RT] : s_reg.cfg[`ESR_IDX_LOWER_RT]);
						end else begin
							s_next.sp = s_reg.sp;
						end
					end else if (con.raise && s_reg.sp < up_fx) begin
						s_next.sp = step_to(s_reg.sp, up_fx, s_reg.cfg[`ESR_IDX_RAISE_RT]);
					end else if (con.lower && s_reg.sp > low_fx) begin
						s_next.sp = step_to(s_reg.sp, low_fx, s_reg.cfg[`ESR_IDX_LOWER_RT]);
					end
				end
				ESR_ST_DECEL: begin
					if (con.rated_sel) begin
						s_next.mode = ESR_ST_ACCEL;
					end else begin
						s_next.sp = step_to(s_reg.sp, idle_fx, s_reg.decel_step);
						if (s_next.sp == idle_fx) begin
							s_next.mode = ESR_ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `ESR_NUM_CFG; i++) begin
				s_reg.cfg[i] <= cfg_reset(i);
			end
			s_reg.ack        <= 1'b0;
			s_reg.rdata      <= 32'h0000_0000;
			s_reg.tick_cnt   <= 16'h0000;
			s_reg.mode       <= ESR_ST_IDLE;
			s_reg.sp         <= {`ESR_RST_IDLE << 16};
			s_reg.in_failed  <= 1'b0;
			s_reg.rem_alarm  <= 1'b0;
			s_reg.accel_step <= 32'h0000_0000;
			s_reg.decel_step <= 32'h0000_0000;
			// Reference starts at the low calibration end
			s_reg.remote_ref <= 16'(`ESR_RST_REM_LOW);
			s_reg.job        <= ESR_JOB_REMOTE;
			s_reg.div_cnt    <= 6'd0;
			s_reg.div_dvd    <= 32'h0000_0000;
			s_reg.div_dsr    <= 16'h0000;
			s_reg.div_rem    <= 17'h0_0000;
			s_reg.div_quo    <= 32'h0000_0000;
			s_reg.rem_neg    <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_ack_o       = s_reg.ack;
	assign wb_dat_o       = s_reg.rdata;
	assign speed_setpoint = s_reg.sp[31:16];
	assign ramp_active    = (s_reg.mode == ESR_ST_ACCEL) || (s_reg.mode == ESR_ST_DECEL);
	assign remote_fail    = s_reg.rem_alarm;

endmodule

// *** rtl/esr_defs.svh ***
// Offsets, field positions, reset values and timing counts of the speed reference ramp
`ifndef ESR_DEFS_SVH
`define ESR_DEFS_SVH

`define ESR_CLK_HZ        20000000
`define ESR_TICK_US       1000
`define ESR_TICK_CYCLES   ((`ESR_CLK_HZ / 1000000) * `ESR_TICK_US)

`define ESR_IDX_CTRL      4'h0
`define ESR_IDX_IDLE      4'h1
`define ESR_IDX_RATED     4'h2
`define ESR_IDX_LOW_LIM   4'h3
`define ESR_IDX_UP_LIM    4'h4
`define ESR_IDX_ACCEL     4'h5
`define ESR_IDX_DECEL     4'h6
`define ESR_IDX_RAISE_RT  4'h7
`define ESR_IDX_LOWER_RT  4'h8
`define ESR_IDX_REM_LOW   4'h9
`define ESR_IDX_REM_HIGH  4'hA
`define ESR_IDX_STATUS    4'hB
`define ESR_IDX_SETPOINT  4'hC
`define ESR_NUM_CFG       11

`define ESR_CTRL_HOLD_BIT 0

`define ESR_RST_CTRL      32'h0000_0001
`define ESR_RST_IDLE      32'h0000_0258
`define ESR_RST_RATED     32'h0000_0708
`define ESR_RST_LOW_LIM   32'h0000_0640
`define ESR_RST_UP_LIM    32'h0000_07D0
`define ESR_RST_ACCEL     32'h0000_2710
`define ESR_RST_DECEL     32'h0000_2710
`define ESR_RST_RAISE_RT  32'h0000_1000
`define ESR_RST_LOWER_RT  32'h0000_1000
`define ESR_RST_REM_LOW   32'h0000_0640
`define ESR_RST_REM_HIGH  32'h0000_07D0

`define ESR_MASK_CTRL     32'h0000_0001
`define ESR_MASK_SPD      32'h0000_FFFF
`define ESR_MASK_RATE     32'hFFFF_FFFF

`define ESR_FAIL_UA       16'h07D0
`define ESR_SPAN_LO_UA    16'h0FA0
`define ESR_SPAN_HI_UA    16'h4E20
`define ESR_SPAN_UA       16'h3E80

`endif

// *** rtl/esr_pkg.sv ***
// Types of the speed reference ramp
package esr_pkg;

	typedef enum logic [1:0] {
		ESR_ST_IDLE  = 2'b00,
		ESR_ST_ACCEL = 2'b01,
		ESR_ST_RATED = 2'b10,
		ESR_ST_DECEL = 2'b11
	} esr_mode_t;

	typedef enum logic [1:0] {
		ESR_JOB_ACCEL  = 2'b00,
		ESR_JOB_DECEL  = 2'b01,
		ESR_JOB_REMOTE = 2'b10
	} esr_job_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} esr_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} esr_wb_rsp_t;

	typedef struct packed {
		logic        raise;
		logic        lower;
		logic        rated_sel;
		logic [15:0] remote_ua;
	} esr_contacts_t;

	typedef struct packed {
		logic [10:0][31:0] cfg;
		logic              ack;
		logic [31:0]       rdata;
		logic [15:0]       tick_cnt;
		esr_mode_t         mode;
		logic [31:0]       sp;
		logic              in_failed;
		logic              rem_alarm;
		logic [31:0]       accel_step;
		logic [31:0]       decel_step;
		logic [15:0]       remote_ref;
		esr_job_t          job;
		logic [5:0]        div_cnt;
		logic [31:0]       div_dvd;
		logic [15:0]       div_dsr;
		logic [16:0]       div_rem;
		logic [31:0]       div_quo;
		logic              rem_neg;
	} esr_state_t;

endpackage

// *** dv/esr_ramp_monitor.sv ***
// Port checker for the speed reference ramp
`timescale 1ns/1ps
module esr_ramp_chk #(
	parameter int TICK_CYCLES = 64
) (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        raise_cmd,
	input wire logic [15:0] remote_ua,
	input wire logic [15:0] speed_setpoint,
	input wire logic        ramp_active,
	input wire logic        remote_fail
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [15:0] prev_reg;
	int          gap_reg;

	// Cycles since the setpoint last moved
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg <= 16'h0000;
			gap_reg  <= 0;
		end else begin
			prev_reg <= speed_setpoint;
			gap_reg  <= (speed_setpoint != prev_reg) ? 0 : gap_reg + 1;
		end
	end

	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_req_gets_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked in the next cycle");
	a_sp_tick_gap: assert property ((speed_setpoint != $past(speed_setpoint)) |-> gap_reg >= TICK_CYCLES - 1)
		else $error("setpoint moved twice within one tick");
	a_reset_idle: assert property ($rose(rst_n) |-> speed_setpoint == 16'h0258 && !ramp_active)
		else $error("setpoint not at idle after reset");
	a_fail_cause: assert property (remote_fail |-> $past(remote_ua, 2) < 16'h07D0)
		else $error("failure flag without a low input");
	a_fail_freeze: assert property (remote_fail |-> $stable(speed_setpoint))
		else $error("setpoint moved while remote failed");
	a_upper_cap: assert property (speed_setpoint <= 16'h07D0)
		else $error("setpoint above upper limit");
	a_no_raise_rise: assert property (!raise_cmd && !$past(raise_cmd) && !ramp_active
		&& !$past(ramp_active) |-> speed_setpoint <= $past(speed_setpoint))
		else $error("setpoint rose without raise or ramp");

	c_ramp: cover property ($rose(ramp_active));
	c_fail: cover property ($rose(remote_fail));
	c_raise: cover property (raise_cmd && speed_setpoint != $past(speed_setpoint));
endmodule

bind esr_ramp esr_ramp_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clock, .rst_n, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .raise_cmd, .remote_ua, .speed_setpoint, .ramp_active, .remote_fail);

// *** dv/esr_switchgear.sv ***
// Switchgear contacts and remote milliamp source facing the ramp
`timescale 1ns/1ps
module esr_switchgear
	import esr_pkg::*;
(
	input  wire esr_contacts_t want,
	input  wire logic          clock,
	input  wire logic          rst_n,
	output esr_contacts_t      drive
);
	// both contacts change on one edge, so remote is never half selected
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			drive <= '0;
		end else begin
			drive <= want;
		end
	end
endmodule

// *** dv/test_engine_speed_reference_ramp.sv ***
// Self-checking bench for the speed reference ramp
`timescale 1ns/1ps
module test_engine_speed_reference_ramp;
	import esr_pkg::*;
	localparam int TICK = 128;
	logic          clock = 1'b0;
	logic          rst_n = 1'b0;
	logic          cyc = 1'b0;
	logic          stb = 1'b0;
	logic          we = 1'b0;
	logic [7:0]    adr = 8'h00;
	logic [31:0]   wdat = 32'h0000_0000;
	logic          ack;
	logic [31:0]   rdat;
	esr_contacts_t want = '0;
	esr_contacts_t drive;
	logic [15:0]   sp;
	logic [15:0]   last_sp = 'x;
	logic          ramp;
	logic          fail;
	logic [15:0]   exp_q[$];
	logic [31:0]   rd_q[$];
	int            failures = 0;
	int            num_checks = 0;
	int            cycles = 0;
	int            ua;
	int            r1;
	int            r2;

	esr_switchgear sg (.want, .clock, .rst_n, .drive);
	esr_ramp #(.TICK_CYCLES(TICK)) dut (.clock, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_ack_o(ack),
		.wb_dat_o(rdat), .raise_cmd(drive.raise), .lower_cmd(drive.lower),
		.rated_sel(drive.rated_sel), .remote_ua(drive.remote_ua), .speed_setpoint(sp),
		.ramp_active(ramp), .remote_fail(fail));

	initial forever #25 clock = ~clock;

	task automatic end_of_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do @(posedge clock); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wb_rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		wb(1'b0, a, 32'h0000_0000);
	endtask

	// Expected setpoints of a slew, the last step landing on the target
	task automatic slew(input int f, input int t, input int s);
		while (f != t) begin
			f = (t > f) ? ((t - f > s) ? f + s : t) : ((f - t > s) ? f - s : t);
			exp_q.push_back(16'(f));
		end
	endtask

	task automatic sw(input logic r, input logic l, input logic q, input int u);
		@(posedge clock);
		want <= '{raise: r, lower: l, rated_sel: q, remote_ua: 16'(u)};
	endtask

	task automatic wt(input int n);
		repeat (n * TICK) @(posedge clock);
	endtask

	always @(negedge clock) begin
		if (sp !== last_sp) begin
			chk("speed_setpoint", exp_q.size() ? exp_q.pop_front() : 'x, sp);
			last_sp = sp;
		end
		if (ack === 1'b1 && we === 1'b0) begin
			chk("read data", rd_q.pop_front(), rdat);
		end
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			end_of_test();
		end
	end

	initial begin
		r1 = $urandom(49546);
		exp_q.push_back(16'h0258);
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		wb_rd(8'h04, 32'h0000_0258);
		wb_rd(8'h3C, 32'h0000_0000);
		wb(1'b1, 8'h04, 32'h0000_0258);
		wb(1'b1, 8'h14, 32'h0000_000A);
		wb(1'b1, 8'h18, 32'h0000_000A);
		wb(1'b1, 8'h1C, 32'h000A_0000);
		wb(1'b1, 8'h20, 32'h000A_0000);
		wb_rd(8'h14, 32'h0000_000A);
		wt(2);
		slew(600, 1800, 120);
		sw(1'b0, 1'b0, 1'b1, 4000);
		wt(3);
		chk("ramp_active", 1, ramp);
		wait (sp == 16'h0708);
		slew(1800, 2000, 10);
		sw(1'b1, 1'b0, 1'b1, 4000);
		wait (sp == 16'h07D0);
		wt(4);
		slew(2000, 1600, 10);
		sw(1'b0, 1'b1, 1'b1, 4000);
		wait (sp == 16'h0640);
		wt(4);
		ua = 4000 + $urandom % 16001;
		r1 = 1600 + 400 * (ua - 4000) / 16000;
		r2 = 2000 - 400 * (ua - 4000) / 16000;
		slew(1600, r1, 10);
		sw(1'b1, 1'b1, 1'b1, ua);
		wait (sp == 16'(r1));
		wt(2);
		sw(1'b0, 1'b0, 1'b1, ua);
		wb(1'b1, 8'h24, 32'h0000_07D0);
		wb(1'b1, 8'h28, 32'h0000_0640);
		wt(2);
		slew(r1, r2, 10);
		sw(1'b1, 1'b1, 1'b1, ua);
		wait (sp == 16'(r2));
		wt(2);
		sw(1'b1, 1'b1, 1'b1, ua % 2000);
		wt(3);
		chk("remote_fail", 0, fail);
		wb(1'b1, 8'h00, 32'h0000_0000);
		wt(1);
		chk("remote_fail", 1, fail);
		slew(r2, 2000, 10);
		sw(1'b1, 1'b1, 1'b1, 4000);
		wt(1);
		chk("remote_fail", 0, fail);
		wait (sp == 16'h07D0);
		wt(2);
		slew(2000, 600, 120);
		sw(1'b0, 1'b0, 1'b0, 4000);
		wait (sp == 16'h0258);
		wt(2);
		chk("ramp_active", 0, ramp);
		wb_rd(8'h04, 32'h0000_0258);
		slew(600, 840, 120);
		sw(1'b0, 1'b0, 1'b1, 4000);
		wait (sp == 16'h0348);
		slew(840, 860, 10);
		sw(1'b1, 1'b0, 1'b1, 4000);
		wait (sp == 16'h035C);
		sw(1'b0, 1'b0, 1'b1, 4000);
		wt(2);
		chk("ramp_active", 0, ramp);
		chk("pending", 0, 32'(exp_q.size()));
		end_of_test();
	end
endmodule
